// ### shared/lbmpc_pkg.sv
/*
 * Constants, field layouts and types of the LCD bias, multiplex and pin block.
 * Assumes an Avalon-MM master and a free-running 32 kHz level on one input.
 */
package lbmpc_pkg;
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_LADDER = 8'h04;
    localparam logic [7:0] OFF_SEGEN  = 8'h08;
    localparam logic [7:0] OFF_SEGDIR = 8'h0c;
    localparam logic [7:0] OFF_COMDIR = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_PIXEL  = 8'h40;
    localparam int         CTRL_BITS   = 13;
    localparam int         LADDER_BITS = 8;
    localparam int         STAT_ACTIVE = 0;
    localparam int         STAT_SHUT   = 1;
    localparam int         STAT_MODEA  = 2;
    localparam logic [4:0] INTERVAL_A_TICKS = 5'h10;
    localparam logic [4:0] INTERVAL_B_TICKS = 5'h1f;
    localparam logic [2:0] SHUTDOWN_CYCLES  = 3'h4;
    localparam logic [1:0] POWER_OFF        = 2'h0;
    localparam logic [1:0] MUX_STATIC       = 2'h0;
    localparam logic [1:0] MUX_HALF         = 2'h1;
    localparam logic [1:0] MUX_THIRD        = 2'h2;
    localparam logic [1:0] MUX_QUARTER      = 2'h3;

    typedef struct packed {
        logic       ref_src_fixed;
        logic [2:0] bias_pin_en;
        logic [2:0] contrast_trim;
        logic       internal_ref_en;
        logic       ref_buffer_autoidle;
        logic       waveform_type_select;
        logic [1:0] common_mux_select;
        logic       module_enable;
    } lbmpc_ctrl_type;

    typedef struct packed {
        logic [1:0] power_a;
        logic [1:0] power_b;
        logic       unused;
        logic [2:0] ladder_a_interval;
    } lbmpc_ladder_type;

    localparam lbmpc_ctrl_type   CTRL_RESET   = '0;
    localparam lbmpc_ladder_type LADDER_RESET = '0;

    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b01,
        BUS_ANSWER = 2'b10
    } lbmpc_bus_type;
endpackage

// ### core/lbmpc_core.sv
/*
 * Configuration, bias gating, ladder timing and pin ownership of the LCD
 * driver, with an Avalon-MM slave. Assumes lf_clock_in is a 32 kHz level
 * synchronous to clock_in; direction bit 1 means input.
 */
`timescale 1ns/1ps
module lbmpc_core #(
    parameter int NSEG = 24
) (
    // Clock and reset
    input  wire logic                 clock_in,
    input  wire logic                 rst_n_in,
    input  wire logic                 lf_clock_in,
    // Avalon-MM slave
    input  wire logic [7:0]           address_in,
    input  wire logic                 read_in,
    input  wire logic                 write_in,
    input  wire logic [31:0]          writedata_in,
    output logic      [31:0]          readdata_out,
    output logic                      waitrequest_out,
    // Bias and ladder
    output logic      [2:0]           contrast_tap_out,
    output logic                      contrast_ladder_on_out,
    output logic                      internal_ref_on_out,
    output logic                      fixed_ref_enable_out,
    output logic                      ref_buffer_on_out,
    output logic      [1:0]           ladder_power_out,
    output logic                      ladder_mode_a_out,
    output logic      [2:0]           bias_pin_en_out,
    // Pins
    output logic      [3:0]           com_lcd_out,
    output logic      [3:0]           com_gpio_oe_out,
    output logic      [NSEG-1:0]      seg_lcd_out,
    output logic      [NSEG-1:0]      seg_gpio_oe_out,
    // Status
    output logic                      module_active_flag_out,
    output logic                      shutdown_pulse_out
);
    lbmpc_pkg::lbmpc_ctrl_type   ctrl, next_ctrl;
    lbmpc_pkg::lbmpc_ladder_type ladder, next_ladder;
    lbmpc_pkg::lbmpc_bus_type    bus, next_bus;
    logic [NSEG-1:0] seg_en, next_seg_en, seg_dir, next_seg_dir;
    logic [3:0]      com_dir, next_com_dir;
    logic [31:0]     pixel [4];
    logic [31:0]     next_pixel [4];
    logic            active, next_active, shut_flag, next_shut_flag;
    logic [2:0]      sd_cnt, next_sd_cnt;
    logic            lf_q, next_lf_q, mode_a, next_mode_a;
    logic [4:0]      lcnt, next_lcnt;
    logic [31:0]     rdata, next_rdata;
    logic            wait_q, next_wait;
    logic [3:0]      com_used;
    logic            wr_ok, ref_on;

    assign wr_ok = write_in && (bus == lbmpc_pkg::BUS_ANSWER);

    // Common usage per multiplex
    always_comb
    begin
        case (ctrl.common_mux_select)
            lbmpc_pkg::MUX_STATIC:  com_used = 4'h1;
            lbmpc_pkg::MUX_HALF:    com_used = 4'h3;
            lbmpc_pkg::MUX_THIRD:   com_used = 4'h7;
            lbmpc_pkg::MUX_QUARTER: com_used = 4'hf;
            default:                com_used = 4'h0;
        endcase
    end

    // Register file and bus
    always_comb
    begin
        next_ctrl      = ctrl;
        next_ladder    = ladder;
        next_seg_en    = seg_en;
        next_seg_dir   = seg_dir;
        next_com_dir   = com_dir;
        next_pixel     = pixel;
        next_shut_flag = shut_flag;
        next_rdata     = rdata;
        next_bus       = bus;
        case (bus)
            lbmpc_pkg::BUS_IDLE:
            begin
                if (read_in || write_in)
                    next_bus = lbmpc_pkg::BUS_ANSWER;
                next_rdata = 32'h0;
                if (read_in)
                begin
                    case (address_in)
                        lbmpc_pkg::OFF_CTRL:
                            next_rdata[lbmpc_pkg::CTRL_BITS-1:0] = ctrl;
                        lbmpc_pkg::OFF_LADDER:
                            next_rdata[lbmpc_pkg::LADDER_BITS-1:0] = ladder & 8'hf7;
                        lbmpc_pkg::OFF_SEGEN:
                            next_rdata[NSEG-1:0] = seg_en;
                        lbmpc_pkg::OFF_SEGDIR:
                            next_rdata[NSEG-1:0] = seg_dir;
                        lbmpc_pkg::OFF_COMDIR:
                            next_rdata[3:0] = com_dir;
                        lbmpc_pkg::OFF_STATUS:
                        begin
                            next_rdata[lbmpc_pkg::STAT_ACTIVE] = active;
                            next_rdata[lbmpc_pkg::STAT_SHUT]   = shut_flag;
                            next_rdata[lbmpc_pkg::STAT_MODEA]  = mode_a;
                        end
                        default:
                            if (address_in[7:4] == lbmpc_pkg::OFF_PIXEL[7:4])
                                next_rdata = pixel[address_in[3:2]];
                    endcase
                end
            end
            lbmpc_pkg::BUS_ANSWER:
            begin
                next_bus = lbmpc_pkg::BUS_IDLE;
                if (wr_ok)
                begin
                    case (address_in)
                        lbmpc_pkg::OFF_CTRL:
                            next_ctrl = writedata_in[lbmpc_pkg::CTRL_BITS-1:0];
                        lbmpc_pkg::OFF_LADDER:
                            next_ladder = writedata_in[lbmpc_pkg::LADDER_BITS-1:0];
                        lbmpc_pkg::OFF_SEGEN:
                            next_seg_en = writedata_in[NSEG-1:0];
                        lbmpc_pkg::OFF_SEGDIR:
                            next_seg_dir = writedata_in[NSEG-1:0];
                        lbmpc_pkg::OFF_COMDIR:
                            next_com_dir = writedata_in[3:0];
                        lbmpc_pkg::OFF_STATUS:
                            if (writedata_in[lbmpc_pkg::STAT_SHUT])
                                next_shut_flag = 1'b0;
                        default:
                            if (address_in[7:4] == lbmpc_pkg::OFF_PIXEL[7:4])
                                next_pixel[address_in[3:2]] = writedata_in;
                    endcase
                end
            end
            default:
                next_bus = lbmpc_pkg::BUS_IDLE;
        endcase
        next_wait = (next_bus != lbmpc_pkg::BUS_ANSWER);
        if (active && !next_active)
            next_shut_flag = 1'b1;
    end

    // Activity and ladder timing
    always_comb
    begin
        next_active = active;
        next_sd_cnt = sd_cnt;
        next_lf_q   = lf_clock_in;
        next_lcnt   = lcnt;
        if (ctrl.module_enable)
        begin
            next_active = 1'b1;
            next_sd_cnt = lbmpc_pkg::SHUTDOWN_CYCLES;
        end
        else if (sd_cnt != 3'h0)
            next_sd_cnt = sd_cnt - 3'h1;
        else
            next_active = 1'b0;
        if (!active)
            next_lcnt = 5'h0;
        else if (lf_clock_in && !lf_q)
        begin
            if (lcnt == (ctrl.waveform_type_select ? lbmpc_pkg::INTERVAL_B_TICKS
                                                   : lbmpc_pkg::INTERVAL_A_TICKS - 5'h1))
                next_lcnt = 5'h0;
            else
                next_lcnt = lcnt + 5'h1;
        end
        // A first, B for the rest
        next_mode_a = (ladder.ladder_a_interval != 3'h0)
                   && (next_lcnt < {2'h0, ladder.ladder_a_interval});
    end

    assign ref_on = active && ctrl.internal_ref_en;

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ctrl      <= lbmpc_pkg::CTRL_RESET;
            ladder    <= lbmpc_pkg::LADDER_RESET;
            seg_en    <= '0;
            seg_dir   <= '1;
            com_dir   <= 4'hf;
            pixel     <= '{default: 32'h0};
            shut_flag <= 1'b0;
            rdata     <= 32'h0;
            bus       <= lbmpc_pkg::BUS_IDLE;
            wait_q    <= 1'b1;
            active    <= 1'b0;
            sd_cnt    <= 3'h0;
            lf_q      <= 1'b0;
            lcnt      <= 5'h0;
            mode_a    <= 1'b0;
            contrast_tap_out       <= 3'h0;
            contrast_ladder_on_out <= 1'b0;
            internal_ref_on_out    <= 1'b0;
            fixed_ref_enable_out   <= 1'b0;
            ref_buffer_on_out      <= 1'b0;
            ladder_power_out       <= lbmpc_pkg::POWER_OFF;
            ladder_mode_a_out      <= 1'b0;
            bias_pin_en_out        <= 3'h0;
            com_lcd_out            <= 4'h0;
            com_gpio_oe_out        <= 4'h0;
            seg_lcd_out            <= '0;
            seg_gpio_oe_out        <= '0;
            shutdown_pulse_out     <= 1'b0;
        end
        else
        begin
            ctrl      <= next_ctrl;
            ladder    <= next_ladder;
            seg_en    <= next_seg_en;
            seg_dir   <= next_seg_dir;
            com_dir   <= next_com_dir;
            pixel     <= next_pixel;
            shut_flag <= next_shut_flag;
            rdata     <= next_rdata;
            bus       <= next_bus;
            wait_q    <= next_wait;
            active    <= next_active;
            sd_cnt    <= next_sd_cnt;
            lf_q      <= next_lf_q;
            lcnt      <= next_lcnt;
            mode_a    <= next_mode_a;
            contrast_tap_out       <= ctrl.contrast_trim;
            contrast_ladder_on_out <= ref_on;
            internal_ref_on_out    <= ref_on;
            fixed_ref_enable_out   <= ref_on && ctrl.ref_src_fixed;
            ref_buffer_on_out      <= ref_on && ctrl.ref_src_fixed
                                   && !(ctrl.ref_buffer_autoidle && !mode_a);
            ladder_power_out       <= !ref_on ? lbmpc_pkg::POWER_OFF
                                   : (mode_a ? ladder.power_a : ladder.power_b);
            ladder_mode_a_out      <= mode_a;
            bias_pin_en_out        <= ctrl.bias_pin_en;
            com_lcd_out            <= active ? com_used : 4'h0;
            com_gpio_oe_out        <= ~(active ? com_used : 4'h0) & ~com_dir;
            seg_lcd_out            <= seg_en;
            seg_gpio_oe_out        <= ~seg_en & ~seg_dir;
            shutdown_pulse_out     <= active && !next_active;
        end
    end

    assign readdata_out           = rdata;
    assign waitrequest_out        = wait_q;
    assign module_active_flag_out = active;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    property p_trim;
        ##1 contrast_ladder_on_out |-> contrast_tap_out == $past(ctrl.contrast_trim);
    endproperty
    a_trim: assert property (p_trim) else $error("trim tap wrong");
    property p_trim_off;
        !active |=> !contrast_ladder_on_out;
    endproperty
    a_trim_off: assert property (p_trim_off) else $error("trim on inactive");
    property p_ref_off;
        !active |=> !internal_ref_on_out && !fixed_ref_enable_out;
    endproperty
    a_ref_off: assert property (p_ref_off) else $error("ref on inactive");
    property p_noref;
        !ctrl.internal_ref_en |=> !contrast_ladder_on_out && ladder_power_out == 2'h0;
    endproperty
    a_noref: assert property (p_noref) else $error("trim without ref");
    property p_idle;
        ctrl.ref_buffer_autoidle && !mode_a |=> !ref_buffer_on_out;
    endproperty
    a_idle: assert property (p_idle) else $error("buffer on in B");
    property p_fvr;
        active && ctrl.internal_ref_en && ctrl.ref_src_fixed |=> fixed_ref_enable_out;
    endproperty
    a_fvr: assert property (p_fvr) else $error("fixed ref not on");
    property p_mux;
        active |=> {1'b0, com_lcd_out}
                   == (5'h2 << $past(ctrl.common_mux_select)) - 5'h1;
    endproperty
    a_mux: assert property (p_mux) else $error("mux decode");
    property p_seg;
        ##1 (seg_lcd_out & seg_gpio_oe_out) == '0 && seg_lcd_out == $past(seg_en);
    endproperty
    a_seg: assert property (p_seg) else $error("segment owner");
    property p_modeb;
        ladder.ladder_a_interval == 3'h0 |=> !mode_a;
    endproperty
    a_modeb: assert property (p_modeb) else $error("mode A at zero");
    property p_shut;
        $fell(active) |-> shutdown_pulse_out && shut_flag;
    endproperty
    a_shut: assert property (p_shut) else $error("no shutdown flag");
    property p_bus;
        (read_in || write_in) && waitrequest_out |-> ##[1:2] !waitrequest_out;
    endproperty
    a_bus: assert property (p_bus) else $error("bus stalls");

    c_shut: cover property ($fell(active));
    c_mode_a: cover property ($rose(mode_a) ##[1:1000] $fell(mode_a));
    c_write: cover property (wr_ok);
endmodule

// ### testbench/lbmpc_glass.sv
/* Passive multiplexed LCD glass seen from the pins.
   Assumes the device owns common and segment drives. */
`timescale 1ns/1ps
module lbmpc_glass #(
    parameter int NSEG = 24
) (
    // Drives from the device
    input  wire logic [3:0]      com_in,
    input  wire logic [NSEG-1:0] seg_in,
    // Load seen by the glass
    output logic      [2:0]      com_count_out,
    output logic      [7:0]      seg_count_out
);
    // Counts backplanes under drive
    always_comb
    begin
        com_count_out = 3'h0;
        for (int i = 0; i < 4; i++)
            com_count_out = com_count_out + {2'h0, com_in[i]};
    end

    // Counts segment lines under drive
    always_comb
    begin
        seg_count_out = 8'h0;
        for (int i = 0; i < NSEG; i++)
            seg_count_out = seg_count_out + {7'h0, seg_in[i]};
    end
endmodule

// ### testbench/lbmpc_core_tb.sv
/* Self-checking bench of the LCD bias, multiplex and pin block.
   Assumes one 20 MHz clock and a bench-made 32 kHz level. */
`timescale 1ns/1ps
module lbmpc_core_tb;
    localparam int          NSEG  = 24;
    localparam logic [31:0] SMASK = 32'h00ffffff;
    logic              clock_in = 1'b0;
    logic              rst_n_in = 1'b0;
    logic              lf       = 1'b0;
    logic [7:0]        addr     = 8'h00;
    logic              rd       = 1'b0;
    logic              wr       = 1'b0;
    logic [31:0]       wdata    = 32'h0;
    logic [31:0]       rdata;
    logic              wait_req;
    logic [2:0]        tap;
    logic              trim_on, iref_on, fref_en, buf_on, mode_a, active, shut;
    logic [1:0]        power;
    logic [2:0]        bias;
    logic [3:0]        com_lcd, com_oe;
    logic [NSEG-1:0]   seg_lcd, seg_oe;
    logic [2:0]        ncom;
    logic [7:0]        nseg;
    int                n_fail = 0;
    int                checked = 0;
    int                seed = 60183;
    int                lfcnt = 0;
    int                pulses = 0;
    int                pix [4];
    logic [31:0]       r, en, dir;
    lbmpc_pkg::lbmpc_ctrl_type   c;
    lbmpc_pkg::lbmpc_ladder_type l;

    always #25 clock_in = ~clock_in;

    // Slow clock level and shutdown pulse count
    always @(posedge clock_in)
    begin
        lfcnt <= (lfcnt == 312) ? 0 : lfcnt + 1;
        if (lfcnt == 312)
            lf <= ~lf;
        if (shut === 1'b1)
            pulses <= pulses + 1;
    end

    lbmpc_core #(.NSEG(NSEG)) dut (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .lf_clock_in(lf),
        .address_in(addr), .read_in(rd), .write_in(wr), .writedata_in(wdata),
        .readdata_out(rdata), .waitrequest_out(wait_req),
        .contrast_tap_out(tap), .contrast_ladder_on_out(trim_on),
        .internal_ref_on_out(iref_on), .fixed_ref_enable_out(fref_en),
        .ref_buffer_on_out(buf_on), .ladder_power_out(power),
        .ladder_mode_a_out(mode_a), .bias_pin_en_out(bias),
        .com_lcd_out(com_lcd), .com_gpio_oe_out(com_oe),
        .seg_lcd_out(seg_lcd), .seg_gpio_oe_out(seg_oe),
        .module_active_flag_out(active), .shutdown_pulse_out(shut)
    );

    lbmpc_glass #(.NSEG(NSEG)) glass (
        .com_in(com_lcd), .seg_in(seg_lcd),
        .com_count_out(ncom), .seg_count_out(nseg)
    );

    task automatic conclude;
        $display("counts: %0d checked, %0d failed", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clock_in);
        addr <= a;
        wdata <= d;
        rd <= ~w;
        wr <= w;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clock_in);
            if (wait_req === 1'b0)
                break;
        end
        r = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (i == 20)
        begin
            n_fail++;
            conclude();
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0);
        cmp(r, exp, what);
    endtask

    task automatic lf_rise;
        int i;
        for (i = 0; i < 1000; i++)
        begin
            @(posedge clock_in);
            if (lfcnt == 312 && lf == 1'b0)
                break;
        end
        if (i == 1000)
        begin
            n_fail++;
            conclude();
        end
        repeat (6) @(posedge clock_in);
    endtask

    initial
    begin
        int k, e, na, iv;
        repeat (3) @(posedge clock_in);
        rst_n_in <= 1'b1;
        cmp(32'(seg_lcd), 32'h0, "segments after reset");
        cmp(32'(seg_oe), 32'h0, "segment oe after reset");
        rdchk(lbmpc_pkg::OFF_SEGEN, 32'h0, "segment enables after reset");
        rdchk(lbmpc_pkg::OFF_CTRL, 32'h0, "control after reset");
        rdchk(8'h30, 32'h0, "unmapped read");
        $display("test reset done");
        for (k = 0; k < 4; k++)
        begin
            pix[k] = $random(seed);
            bus(1'b1, lbmpc_pkg::OFF_PIXEL + 8'(4 * k), pix[k]);
        end
        for (k = 0; k < 4; k++)
            rdchk(lbmpc_pkg::OFF_PIXEL + 8'(4 * k), pix[k], "pixel word");
        $display("test pixels done");
        for (k = 0; k < 4; k++)
        begin
            en = $random(seed) & SMASK;
            dir = $random(seed) & SMASK;
            bus(1'b1, lbmpc_pkg::OFF_SEGEN, en);
            bus(1'b1, lbmpc_pkg::OFF_SEGDIR, dir);
            repeat (4) @(posedge clock_in);
            cmp(32'(seg_lcd), en, "segment owner");
            cmp(32'(seg_oe), ~en & ~dir & SMASK, "segment gpio oe");
            na = 0;
            for (e = 0; e < NSEG; e++)
                na += int'(en[e]);
            cmp(32'(nseg), na, "glass segments");
        end
        $display("test segments done");
        dir = $random(seed) & 32'hf;
        bus(1'b1, lbmpc_pkg::OFF_COMDIR, dir);
        for (k = 0; k < 4; k++)
        begin
            c = '0;
            c.module_enable = 1'b1;
            c.common_mux_select = 2'(k);
            bus(1'b1, lbmpc_pkg::OFF_CTRL, 32'(c));
            repeat (4) @(posedge clock_in);
            en = (32'h2 << k) - 32'h1;
            cmp(32'(com_lcd), en, "common drive");
            cmp(32'(com_oe), ~en & ~dir & 32'hf, "common gpio oe");
            cmp(32'(ncom), 32'(k + 1), "glass commons");
        end
        $display("test multiplex done");
        c.internal_ref_en = 1'b1;
        for (k = 0; k < 8; k++)
        begin
            c.contrast_trim = 3'(k);
            c.bias_pin_en = 3'(7 - k);
            bus(1'b1, lbmpc_pkg::OFF_CTRL, 32'(c));
            repeat (4) @(posedge clock_in);
            cmp(32'(tap), 32'(k), "trim tap");
            cmp(32'(trim_on), 32'h1, "trim ladder closed");
            cmp(32'(bias), 32'(7 - k), "bias pin enables");
            cmp(32'(iref_on), 32'h1, "reference kept with bias pins");
            cmp(32'(fref_en), 32'h0, "fixed reference idle on supply source");
            cmp(32'(buf_on), 32'h0, "buffer off on supply source");
        end
        c.internal_ref_en = 1'b0;
        bus(1'b1, lbmpc_pkg::OFF_CTRL, 32'(c));
        repeat (4) @(posedge clock_in);
        cmp(32'(trim_on), 32'h0, "trim off without reference");
        c.internal_ref_en = 1'b1;
        c.module_enable = 1'b0;
        bus(1'b1, lbmpc_pkg::OFF_CTRL, 32'(c));
        for (e = 0; e < 40 && active !== 1'b0; e++)
            @(posedge clock_in);
        if (e == 40)
        begin
            n_fail++;
            conclude();
        end
        repeat (3) @(posedge clock_in);
        cmp(32'(active), 32'h0, "module shut down");
        cmp(32'(trim_on), 32'h0, "trim open when inactive");
        cmp(32'(iref_on), 32'h0, "reference off when inactive");
        cmp(pulses, 32'h1, "shutdown pulse");
        rdchk(lbmpc_pkg::OFF_STATUS, 32'h2, "shutdown flag");
        bus(1'b1, lbmpc_pkg::OFF_STATUS, 32'h2);
        rdchk(lbmpc_pkg::OFF_STATUS, 32'h0, "shutdown flag cleared");
        $display("test bias done");
        for (k = 0; k < 4; k++)
        begin
            iv = (k == 0) ? 0 : (k == 1) ? 3 : 7;
            l = '0;
            l.power_a = 2'(3 - k);
            l.power_b = 2'(k);
            l.ladder_a_interval = 3'(iv);
            bus(1'b1, lbmpc_pkg::OFF_LADDER, 32'(l) | 32'h8);
            rdchk(lbmpc_pkg::OFF_LADDER, 32'(l), "ladder readback");
            c = '0;
            c.module_enable = 1'b1;
            c.internal_ref_en = 1'b1;
            c.ref_src_fixed = 1'b1;
            c.ref_buffer_autoidle = (k != 2);
            c.waveform_type_select = (k == 3);
            bus(1'b1, lbmpc_pkg::OFF_CTRL, 32'(c));
            lf_rise();
            na = 0;
            for (e = 0; e < ((k == 3) ? 32 : 16); e++)
            begin
                lf_rise();
                na += (mode_a === 1'b1) ? 1 : 0;
                cmp(32'(power), (mode_a === 1'b1) ? 32'(3 - k) : 32'(k), "ladder power");
                cmp(32'(buf_on), (mode_a === 1'b1 || k == 2) ? 32'h1 : 32'h0,
                    "buffer autoidle");
            end
            cmp(na, iv, "mode A clocks per interval");
            cmp(32'(fref_en), 32'h1, "fixed reference auto enable");
        end
        $display("test ladder done");
        conclude();
    end
endmodule
